// ===== inc/foar_pkg.sv
// constants, types and carriers of the fieldbus object access responder
// assumes one system clock; request fields valid in the cycle REQ_VALID is high
package foar_pkg;
  localparam logic [15:0] IDX_CMD   = 16'h6040;
  localparam logic [15:0] IDX_STATE = 16'h6041;
  localparam logic [15:0] IDX_VSET  = 16'h6042;
  localparam logic [15:0] IDX_VDEM  = 16'h6043;
  localparam logic [15:0] IDX_VMEAS = 16'h6044;
  localparam logic [15:0] IDX_ACC   = 16'h604F;
  localparam logic [15:0] IDX_DEC   = 16'h6050;
  localparam logic [15:0] IDX_MREQ  = 16'h6060;
  localparam logic [15:0] IDX_MACT  = 16'h6061;
  localparam logic [15:0] IDX_MAP   = 16'h1600;
  localparam int          AT_SPEED_BIT = 10;
  localparam int          MAP_ENTRIES  = 8;
  localparam logic [9:0]  MAP_MAX_BITS = 10'h040;
  localparam logic [7:0]  MODE_NONE    = 8'h00;
  localparam logic [7:0]  MODE_VEL     = 8'h02;
  localparam logic [2:0]  SEG_MAX_B    = 3'h4;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [31:0] AB_NONE      = 32'h00000000;
  localparam logic [31:0] AB_TOGGLE    = 32'h05030000;
  localparam logic [31:0] AB_TIMEOUT   = 32'h05040000;
  localparam logic [31:0] AB_BAD_CMD   = 32'h05040001;
  localparam logic [31:0] AB_OVERFLOW  = 32'h05040005;
  localparam logic [31:0] AB_READ_WO   = 32'h06010001;
  localparam logic [31:0] AB_WRITE_RO  = 32'h06010002;
  localparam logic [31:0] AB_SUB_NZ    = 32'h06010003;
  localparam logic [31:0] AB_NO_OBJ    = 32'h06020000;
  localparam logic [31:0] AB_NO_MAP    = 32'h06040041;
  localparam logic [31:0] AB_MAP_FULL  = 32'h06040042;
  localparam logic [31:0] AB_STORE_HW  = 32'h06060000;
  localparam logic [31:0] AB_LEN       = 32'h06070010;
  localparam logic [31:0] AB_LEN_LONG  = 32'h06070012;
  localparam logic [31:0] AB_LEN_SHORT = 32'h06070013;
  localparam logic [31:0] AB_NO_SUB    = 32'h06090011;
  localparam logic [31:0] AB_RANGE     = 32'h06090030;
  localparam logic [31:0] AB_TOO_BIG   = 32'h06090031;
  localparam logic [31:0] AB_TOO_SMALL = 32'h06090032;
  localparam logic [31:0] AB_IDENT     = 32'h06090033;
  localparam logic [31:0] AB_LOW_LIM   = 32'h06090036;
  localparam logic [31:0] AB_NO_XFER   = 32'h08000020;
  localparam logic [31:0] AB_LOCAL     = 32'h08000021;
  localparam logic [31:0] AB_STATE     = 32'h08000022;
  // event numbers 81, 89, 111, 161
  localparam logic [7:0]  EV_NONE      = 8'h00;
  localparam logic [7:0]  EV_LINK      = 8'h51;
  localparam logic [7:0]  EV_DETACH    = 8'h59;
  localparam logic [7:0]  EV_SYNC_WARN = 8'h6F;
  localparam logic [7:0]  EV_SYNC_FLT  = 8'hA1;
  localparam int CLK_MHZ         = 100;
  localparam int SDO_TIMEOUT_US  = 1000;
  localparam int LINK_TIMEOUT_US = 1000;
  localparam int SYNC_TIMEOUT_US = 1000;
  localparam int SDO_TIMEOUT_CYC  = SDO_TIMEOUT_US * CLK_MHZ;
  localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * CLK_MHZ;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CMD_READ     = 3'h0,
    CMD_WRITE    = 3'h1,
    CMD_SEG_INIT = 3'h3,
    CMD_SEG_DATA = 3'h2
  } foar_cmd_e;
  typedef enum logic [1:0] {
    ACC_NONE = 2'h0,
    ACC_RO   = 2'h1,
    ACC_RW   = 2'h3,
    ACC_WO   = 2'h2
  } foar_acc_e;
  typedef enum logic {
    SEG_IDLE = 1'b0,
    SEG_RUN  = 1'b1
  } foar_seg_e;
  typedef struct packed {
    foar_cmd_e   cmd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [2:0]  len;
    logic [31:0] data;
    logic        toggle;
    logic        last;
  } foar_req_s;
  typedef struct packed {
    logic        abort;
    logic [31:0] code;
    logic [2:0]  len;
    logic [31:0] data;
  } foar_rsp_s;
endpackage : foar_pkg

// ===== verilog/foar_top.sv
// object access responder: checks each access, stores drive objects, raises link events
// assumes all inputs synchronous to CLK_SYS; one request per cycle may be offered
`timescale 1ns/1ps
module foar_top #(
  parameter int unsigned SDO_TIMEOUT  = foar_pkg::SDO_TIMEOUT_CYC,
  parameter int unsigned LINK_TIMEOUT = foar_pkg::LINK_TIMEOUT_CYC,
  parameter int unsigned SYNC_TIMEOUT = foar_pkg::SYNC_TIMEOUT_CYC
) (
  input  wire logic                CLK_SYS,
  input  wire logic                SYS_RST,
  input  wire logic                CLK_EN,
  input  wire logic                REQ_VALID,
  input  wire foar_pkg::foar_req_s REQ,
  input  wire logic [15:0]         DRIVE_STATUS,
  input  wire logic                MOTOR_AT_SPEED,
  input  wire logic [15:0]         VELOCITY_DEMAND,
  input  wire logic [15:0]         VELOCITY_MEASURED,
  input  wire logic [7:0]          MODE_ACTIVE,
  input  wire logic [15:0]         VELOCITY_LOWER_LIMIT,
  input  wire logic                XFER_BLOCKED,
  input  wire logic                LOCAL_CONTROL,
  input  wire logic                STATE_BLOCKED,
  input  wire logic                STORE_FAILED,
  input  wire logic                IDENT_MISMATCH,
  input  wire logic                HOST_FRAME,
  input  wire logic                SYNC_MODE,
  input  wire logic                SYNC_PACKET,
  input  wire logic                CMD_FROM_CARD,
  input  wire logic                CARD_PRESENT,
  output logic                     RSP_VALID,
  output foar_pkg::foar_rsp_s      RSP,
  output logic [15:0]              DRIVE_COMMAND,
  output logic [15:0]              VELOCITY_SETPOINT,
  output logic [15:0]              ACCEL_RAMP_TIME,
  output logic [15:0]              DECEL_RAMP_TIME,
  output logic [7:0]               MODE_REQUEST,
  output logic                     LINK_TIMEOUT_WARNING,
  output logic                     SYNC_LOSS_WARNING,
  output logic                     SYNC_LOSS_FAULT,
  output logic                     CARD_DETACHED_WARNING,
  output logic [7:0]               EVENT_ID
);
  // ----------------------------------------------------------------
  // object decode
  // ----------------------------------------------------------------
  function automatic foar_pkg::foar_acc_e f_acc(input logic [15:0] idx);
    unique case (idx)
      foar_pkg::IDX_CMD, foar_pkg::IDX_VSET, foar_pkg::IDX_ACC, foar_pkg::IDX_DEC,
      foar_pkg::IDX_MREQ, foar_pkg::IDX_MAP: f_acc = foar_pkg::ACC_RW;
      foar_pkg::IDX_STATE, foar_pkg::IDX_VDEM, foar_pkg::IDX_VMEAS,
      foar_pkg::IDX_MACT: f_acc = foar_pkg::ACC_RO;
      default: f_acc = foar_pkg::ACC_NONE;
    endcase
  endfunction : f_acc

  function automatic logic [2:0] f_size(input logic [15:0] idx, input logic [7:0] sub);
    if (idx == foar_pkg::IDX_MAP)
      f_size = (sub == 8'h00) ? 3'h1 : 3'h4;
    else if (idx == foar_pkg::IDX_MREQ || idx == foar_pkg::IDX_MACT)
      f_size = 3'h1;
    else
      f_size = 3'h2;
  endfunction : f_size

  function automatic logic f_mappable(input logic [15:0] idx);
    f_mappable = idx == foar_pkg::IDX_CMD || idx == foar_pkg::IDX_STATE || idx == foar_pkg::IDX_VSET ||
                 idx == foar_pkg::IDX_VMEAS || idx == foar_pkg::IDX_MREQ || idx == foar_pkg::IDX_MACT;
  endfunction : f_mappable

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  foar_pkg::foar_seg_e seg_st;
  logic [15:0]         seg_idx;
  logic [7:0]          seg_sub, map_cnt;
  logic                seg_tgl;
  logic [2:0]          seg_bytes;
  logic [31:0]         seg_buf, seg_tmr;
  logic [31:0]         map_ent [foar_pkg::MAP_ENTRIES];
  logic [31:0]         link_tmr, sync_tmr;

  foar_pkg::foar_req_s eff;
  foar_pkg::foar_acc_e acc;
  logic [31:0]         pre, chk, rd, new_buf;
  logic                take, wr, rec, seg_end, seg_step, seg_tout, wr_ok;
  logic [2:0]          sz, new_len;
  logic [11:0]         sum_ex, sum_n;

  // ----------------------------------------------------------------
  // request evaluation
  // ----------------------------------------------------------------
  always_comb begin
    eff      = REQ;
    pre      = foar_pkg::AB_NONE;
    take     = 1'b0;
    seg_end  = 1'b0;
    seg_step = 1'b0;
    new_len  = 3'(seg_bytes + REQ.len);
    new_buf  = seg_buf | (REQ.data << {seg_bytes, 3'b000});
    seg_tout = seg_st == foar_pkg::SEG_RUN && seg_tmr >= 32'(SDO_TIMEOUT - 1) && !REQ_VALID;
    if (REQ_VALID) begin
      unique case (REQ.cmd)
        foar_pkg::CMD_READ, foar_pkg::CMD_WRITE: take = 1'b1;
        foar_pkg::CMD_SEG_INIT: take = 1'b0;
        foar_pkg::CMD_SEG_DATA: begin
          seg_end = 1'b1;
          if (seg_st == foar_pkg::SEG_IDLE)
            pre = foar_pkg::AB_BAD_CMD;
          else if (REQ.toggle != seg_tgl)
            pre = foar_pkg::AB_TOGGLE;
          else if ({1'b0, seg_bytes} + {1'b0, REQ.len} > {1'b0, foar_pkg::SEG_MAX_B})
            pre = foar_pkg::AB_OVERFLOW;
          else if (REQ.last) begin
            take      = 1'b1;
            eff.cmd   = foar_pkg::CMD_WRITE;
            eff.index = seg_idx;
            eff.sub   = seg_sub;
            eff.len   = new_len;
            eff.data  = new_buf;
          end else begin
            seg_end  = 1'b0;
            seg_step = 1'b1;
          end
        end
        default: pre = foar_pkg::AB_BAD_CMD;
      endcase
    end
  end

  always_comb begin
    sum_ex = 12'h000;
    sum_n  = 12'h000;
    for (int i = 0; i < foar_pkg::MAP_ENTRIES; i++) begin
      if (8'(i) < map_cnt && 8'(i + 1) != eff.sub)
        sum_ex = sum_ex + {4'h0, map_ent[i][7:0]};
      if (8'(i) < eff.data[7:0])
        sum_n = sum_n + {4'h0, map_ent[i][7:0]};
    end
  end

  // checks in fixed order; the first failure is the only answer
  always_comb begin
    wr  = eff.cmd == foar_pkg::CMD_WRITE;
    rec = eff.index == foar_pkg::IDX_MAP;
    acc = f_acc(eff.index);
    sz  = f_size(eff.index, eff.sub);
    chk = foar_pkg::AB_NONE;
    if (acc == foar_pkg::ACC_NONE)
      chk = foar_pkg::AB_NO_OBJ;
    else if (!rec && eff.sub != 8'h00)
      chk = wr ? foar_pkg::AB_SUB_NZ : foar_pkg::AB_NO_SUB;
    else if (rec && eff.sub > 8'(foar_pkg::MAP_ENTRIES))
      chk = foar_pkg::AB_NO_SUB;
    else if (!wr && acc == foar_pkg::ACC_WO)
      chk = foar_pkg::AB_READ_WO;
    else if (wr && acc == foar_pkg::ACC_RO)
      chk = foar_pkg::AB_WRITE_RO;
    else if (wr && XFER_BLOCKED)
      chk = foar_pkg::AB_NO_XFER;
    else if (wr && LOCAL_CONTROL)
      chk = foar_pkg::AB_LOCAL;
    else if (wr && STATE_BLOCKED)
      chk = foar_pkg::AB_STATE;
    else if (wr && rec && IDENT_MISMATCH)
      chk = foar_pkg::AB_IDENT;
    else if (wr && eff.len == 3'h0)
      chk = foar_pkg::AB_LEN;
    else if (wr && eff.len > sz)
      chk = foar_pkg::AB_LEN_LONG;
    else if (wr && eff.len < sz)
      chk = foar_pkg::AB_LEN_SHORT;
    else if (wr && eff.index == foar_pkg::IDX_MREQ &&
             eff.data[7:0] != foar_pkg::MODE_VEL && eff.data[7:0] != foar_pkg::MODE_NONE)
      chk = foar_pkg::AB_RANGE;
    else if (wr && (eff.index == foar_pkg::IDX_ACC || eff.index == foar_pkg::IDX_DEC) && eff.data[15])
      chk = foar_pkg::AB_TOO_SMALL;
    else if (wr && eff.index == foar_pkg::IDX_VSET &&
             $signed(eff.data[15:0]) < $signed(VELOCITY_LOWER_LIMIT))
      chk = foar_pkg::AB_LOW_LIM;
    else if (wr && rec && eff.sub == 8'h00 && eff.data[7:0] > 8'(foar_pkg::MAP_ENTRIES))
      chk = foar_pkg::AB_TOO_BIG;
    else if (wr && rec && eff.sub == 8'h00 && sum_n > {2'b00, foar_pkg::MAP_MAX_BITS})
      chk = foar_pkg::AB_MAP_FULL;
    else if (wr && rec && eff.sub != 8'h00 && !f_mappable(eff.data[31:16]))
      chk = foar_pkg::AB_NO_MAP;
    else if (wr && rec && eff.sub != 8'h00 && sum_ex + {4'h0, eff.data[7:0]} > {2'b00, foar_pkg::MAP_MAX_BITS})
      chk = foar_pkg::AB_MAP_FULL;
    else if (wr && STORE_FAILED)
      chk = foar_pkg::AB_STORE_HW;
  end

  always_comb begin
    rd = 32'h00000000;
    unique case (eff.index)
      foar_pkg::IDX_CMD:   rd = {16'h0000, DRIVE_COMMAND};
      foar_pkg::IDX_STATE: rd = {16'h0000, DRIVE_STATUS[15:11], MOTOR_AT_SPEED, DRIVE_STATUS[9:0]};
      foar_pkg::IDX_VSET:  rd = {16'h0000, VELOCITY_SETPOINT};
      foar_pkg::IDX_VDEM:  rd = {16'h0000, VELOCITY_DEMAND};
      foar_pkg::IDX_VMEAS: rd = {16'h0000, VELOCITY_MEASURED};
      foar_pkg::IDX_ACC:   rd = {16'h0000, ACCEL_RAMP_TIME};
      foar_pkg::IDX_DEC:   rd = {16'h0000, DECEL_RAMP_TIME};
      foar_pkg::IDX_MREQ:  rd = {24'h000000, MODE_REQUEST};
      foar_pkg::IDX_MACT:  rd = {24'h000000, MODE_ACTIVE};
      foar_pkg::IDX_MAP:   rd = (eff.sub == 8'h00) ? {24'h000000, map_cnt} : map_ent[eff.sub[2:0] - 3'h1];
      default:             rd = 32'h00000000;
    endcase
  end

  assign wr_ok = take && wr && chk == foar_pkg::AB_NONE;

  // ----------------------------------------------------------------
  // response
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      RSP_VALID <= 1'b0;
      RSP       <= '0;
    end else if (CLK_EN) begin
      RSP_VALID <= REQ_VALID || seg_tout;
      RSP       <= '0;
      if (seg_tout) begin
        RSP.abort <= 1'b1;
        RSP.code  <= foar_pkg::AB_TIMEOUT;
      end else if (pre != foar_pkg::AB_NONE) begin
        RSP.abort <= 1'b1;
        RSP.code  <= pre;
      end else if (take && chk != foar_pkg::AB_NONE) begin
        RSP.abort <= 1'b1;
        RSP.code  <= chk;
      end else if (take && !wr) begin
        RSP.len  <= sz;
        RSP.data <= rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // segmented transfer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      seg_st    <= foar_pkg::SEG_IDLE;
      seg_idx   <= foar_pkg::RST_WORD;
      seg_sub   <= foar_pkg::RST_BYTE;
      seg_tgl   <= 1'b0;
      seg_bytes <= 3'h0;
      seg_buf   <= 32'h00000000;
      seg_tmr   <= 32'h00000000;
    end else if (CLK_EN) begin
      if (REQ_VALID && REQ.cmd == foar_pkg::CMD_SEG_INIT) begin
        seg_st    <= foar_pkg::SEG_RUN;
        seg_idx   <= REQ.index;
        seg_sub   <= REQ.sub;
        seg_tgl   <= 1'b0;
        seg_bytes <= 3'h0;
        seg_buf   <= 32'h00000000;
        seg_tmr   <= 32'h00000000;
      end else if (seg_step) begin
        seg_tgl   <= ~seg_tgl;
        seg_bytes <= new_len;
        seg_buf   <= new_buf;
        seg_tmr   <= 32'h00000000;
      end else if (seg_end || seg_tout) begin
        seg_st <= foar_pkg::SEG_IDLE;
      end else if (seg_st == foar_pkg::SEG_RUN) begin
        seg_tmr <= seg_tmr + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // object store
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      DRIVE_COMMAND     <= foar_pkg::RST_WORD;
      VELOCITY_SETPOINT <= foar_pkg::RST_WORD;
      ACCEL_RAMP_TIME   <= foar_pkg::RST_WORD;
      DECEL_RAMP_TIME   <= foar_pkg::RST_WORD;
      MODE_REQUEST      <= foar_pkg::RST_BYTE;
    end else if (CLK_EN && wr_ok) begin
      unique case (eff.index)
        foar_pkg::IDX_CMD:  DRIVE_COMMAND     <= eff.data[15:0];
        foar_pkg::IDX_VSET: VELOCITY_SETPOINT <= eff.data[15:0];
        foar_pkg::IDX_ACC:  ACCEL_RAMP_TIME   <= eff.data[15:0];
        foar_pkg::IDX_DEC:  DECEL_RAMP_TIME   <= eff.data[15:0];
        foar_pkg::IDX_MREQ: MODE_REQUEST      <= eff.data[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      map_cnt <= foar_pkg::RST_BYTE;
      for (int i = 0; i < foar_pkg::MAP_ENTRIES; i++)
        map_ent[i] <= 32'h00000000;
    end else if (CLK_EN && wr_ok && rec) begin
      if (eff.sub == 8'h00)
        map_cnt <= eff.data[7:0];
      else
        map_ent[eff.sub[2:0] - 3'h1] <= eff.data;
    end
  end

  // ----------------------------------------------------------------
  // link events
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      link_tmr             <= 32'h00000000;
      LINK_TIMEOUT_WARNING <= 1'b0;
    end else if (CLK_EN) begin
      if (HOST_FRAME || REQ_VALID) begin
        link_tmr             <= 32'h00000000;
        LINK_TIMEOUT_WARNING <= 1'b0;
      end else if (link_tmr >= 32'(LINK_TIMEOUT - 1)) begin
        LINK_TIMEOUT_WARNING <= 1'b1;
      end else begin
        link_tmr <= link_tmr + 32'h00000001;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync_tmr          <= 32'h00000000;
      SYNC_LOSS_WARNING <= 1'b0;
      SYNC_LOSS_FAULT   <= 1'b0;
    end else if (CLK_EN) begin
      if (!SYNC_MODE || SYNC_PACKET) begin
        sync_tmr          <= 32'h00000000;
        SYNC_LOSS_WARNING <= 1'b0;
        SYNC_LOSS_FAULT   <= 1'b0;
      end else if (sync_tmr >= 32'(SYNC_TIMEOUT - 1)) begin
        SYNC_LOSS_FAULT   <= CMD_FROM_CARD;
        SYNC_LOSS_WARNING <= ~CMD_FROM_CARD;
      end else begin
        sync_tmr <= sync_tmr + 32'h00000001;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST)
      CARD_DETACHED_WARNING <= 1'b0;
    else if (CLK_EN)
      CARD_DETACHED_WARNING <= ~CARD_PRESENT;
  end

  // highest-severity active event number, one cycle behind the flags
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST)
      EVENT_ID <= foar_pkg::EV_NONE;
    else if (CLK_EN) begin
      if (SYNC_LOSS_FAULT)
        EVENT_ID <= foar_pkg::EV_SYNC_FLT;
      else if (SYNC_LOSS_WARNING)
        EVENT_ID <= foar_pkg::EV_SYNC_WARN;
      else if (CARD_DETACHED_WARNING)
        EVENT_ID <= foar_pkg::EV_DETACH;
      else if (LINK_TIMEOUT_WARNING)
        EVENT_ID <= foar_pkg::EV_LINK;
      else
        EVENT_ID <= foar_pkg::EV_NONE;
    end
  end
endmodule : foar_top

// ===== tb/foar_monitor.sv
// assertions on the responder's answers, stored objects and event flags
// assumes one clock domain; bound to the top module
`timescale 1ns/1ps
module foar_monitor (
  input wire logic                CLK_SYS,
  input wire logic                SYS_RST,
  input wire logic                CLK_EN,
  input wire logic                REQ_VALID,
  input wire foar_pkg::foar_req_s REQ,
  input wire logic                MOTOR_AT_SPEED,
  input wire logic                CARD_PRESENT,
  input wire logic                RSP_VALID,
  input wire foar_pkg::foar_rsp_s RSP,
  input wire logic [15:0]         VELOCITY_SETPOINT,
  input wire logic                SYNC_LOSS_FAULT,
  input wire logic                CARD_DETACHED_WARNING,
  input wire logic [7:0]          EVENT_ID
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_take(c, i);
    CLK_EN && REQ_VALID && REQ.cmd == c && REQ.index == i && REQ.sub == 8'h00;
  endsequence
  chk_answer_next: assert property (CLK_EN && REQ_VALID |=> RSP_VALID) else $error("no answer");
  chk_quiet_idle: assert property (!RSP_VALID |-> RSP == '0) else $error("stray answer");
  chk_speed_bit: assert property (s_take(foar_pkg::CMD_READ, foar_pkg::IDX_STATE)
    |=> RSP.data[10] == $past(MOTOR_AT_SPEED)) else $error("bad speed bit");
  chk_ro_refused: assert property (s_take(foar_pkg::CMD_WRITE, foar_pkg::IDX_VMEAS)
    |=> RSP.abort && RSP.code == foar_pkg::AB_WRITE_RO) else $error("ro write taken");
  chk_ro_stable: assert property (RSP_VALID && RSP.abort |-> $stable(VELOCITY_SETPOINT)) else $error("abort wrote");
  chk_bad_command: assert property (CLK_EN && REQ_VALID && REQ.cmd > 3
    |=> RSP.abort && RSP.code == foar_pkg::AB_BAD_CMD) else $error("bad command taken");
  chk_detach_flag: assert property (CLK_EN && !CARD_PRESENT |=> CARD_DETACHED_WARNING) else $error("no detach");
  chk_fault_event: assert property (CLK_EN && SYNC_LOSS_FAULT |=> EVENT_ID == foar_pkg::EV_SYNC_FLT)
    else $error("bad fault number");
endmodule : foar_monitor

// ===== tb/foar_host_model.sv
// host controller model: one object access at a time
// assumes the answer is registered on the taking edge itself and read 1 ns after it
`timescale 1ns/1ps
module foar_host_model (
  input  wire logic                CLK_SYS,
  input  wire logic                RSP_VALID,
  input  wire foar_pkg::foar_rsp_s RSP,
  output logic                     REQ_VALID = 1'b0,
  output foar_pkg::foar_req_s      REQ = '0
);
  // request held over its edge; idle fields inverted so stale values never match
  task automatic xfer(input foar_pkg::foar_req_s r, output logic v, output foar_pkg::foar_rsp_s s);
    REQ_VALID = 1'b1;
    REQ = r;
    @(posedge CLK_SYS);
    #1;
    v = RSP_VALID;
    s = RSP;
    REQ_VALID = 1'b0;
    REQ = ~r;
    @(posedge CLK_SYS);
    #1;
  endtask : xfer
endmodule : foar_host_model

// ===== tb/tb_top.sv
// self-checking bench: random object traffic plus corner accesses
// assumes the host model and short timeout parameters
`timescale 1ns/1ps
module tb_top;
  localparam int TMO = 20;
  logic CLK_SYS, SYS_RST, CLK_EN, REQ_VALID, MOTOR_AT_SPEED, XFER_BLOCKED, LOCAL_CONTROL, STATE_BLOCKED, rv;
  logic STORE_FAILED, IDENT_MISMATCH, HOST_FRAME, SYNC_MODE, SYNC_PACKET, CMD_FROM_CARD, CARD_PRESENT;
  logic RSP_VALID, LINK_TIMEOUT_WARNING, SYNC_LOSS_WARNING, SYNC_LOSS_FAULT, CARD_DETACHED_WARNING;
  logic [15:0] DRIVE_STATUS, VELOCITY_DEMAND, VELOCITY_MEASURED, VELOCITY_LOWER_LIMIT, DRIVE_COMMAND, v;
  logic [15:0] VELOCITY_SETPOINT, ACCEL_RAMP_TIME, DECEL_RAMP_TIME;
  logic [7:0]  MODE_ACTIVE, MODE_REQUEST, EVENT_ID;
  foar_pkg::foar_req_s REQ;
  foar_pkg::foar_rsp_s RSP, rs;
  int n_errors = 0, compares = 0, cyc = 0;

  foar_top #(.SDO_TIMEOUT(TMO), .LINK_TIMEOUT(TMO), .SYNC_TIMEOUT(TMO)) i_foar_top (.*);
  foar_host_model i_foar_host_model (.*);

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [31:0] exp_state(input logic [15:0] s, input logic a);
    return {16'h0000, s[15:11], a, s[9:0]};
  endfunction : exp_state
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic acc(input logic [31:0] ex, input logic [15:0] ix, input logic [2:0] c = 1, input logic [2:0] ln = 2,
                     input logic [7:0] sb = 0, input logic [31:0] d = 0, input logic [6:0] fl = 0);
    {XFER_BLOCKED, LOCAL_CONTROL, STATE_BLOCKED, STORE_FAILED, IDENT_MISMATCH} = fl[6:2];
    i_foar_host_model.xfer({c, ix, sb, ln, d, fl[1:0]}, rv, rs);
    chk({rv, rs.abort, rs.code}, {1'b1, ex != 0, ex});
  endtask : acc

  initial begin
    {SYS_RST, CLK_EN, HOST_FRAME, SYNC_MODE, SYNC_PACKET, CMD_FROM_CARD, CARD_PRESENT} = 7'h61;
    {DRIVE_STATUS, MOTOR_AT_SPEED, VELOCITY_DEMAND, VELOCITY_MEASURED, MODE_ACTIVE} = '0;
    {XFER_BLOCKED, LOCAL_CONTROL, STATE_BLOCKED, STORE_FAILED, IDENT_MISMATCH} = '0;
    VELOCITY_LOWER_LIMIT = 16'h0010;
    void'($urandom(32'hF74C));
    repeat (6) @(posedge CLK_SYS);
    #1 SYS_RST = 1'b0;
    repeat (8) begin
      {DRIVE_STATUS, MOTOR_AT_SPEED, VELOCITY_DEMAND, VELOCITY_MEASURED, MODE_ACTIVE} = 57'({$urandom, $urandom});
      v = 16'($urandom_range(32'h7FFF, 32'h0010));
      acc(0, 16'h6042, 1, 2, 0, {16'h0000, v});
      chk(VELOCITY_SETPOINT, v);
      acc(0, 16'h6050, 1, 2, 0, {16'h0000, v});
      chk(DECEL_RAMP_TIME, v);
      acc(0, 16'h6060, 1, 1, 0, {30'h0, v[0], 1'b0});
      chk(MODE_REQUEST, {6'h0, v[0], 1'b0});
      acc(0, 16'h6041, 0);
      chk({rs.len, rs.data}, {3'h2, exp_state(DRIVE_STATUS, MOTOR_AT_SPEED)});
      acc(0, 16'h6044, 0);
      chk({rs.len, rs.data}, {3'h2, 16'h0000, VELOCITY_MEASURED});
      acc(0, 16'h6061, 0);
      chk({rs.len, rs.data}, {3'h1, 24'h0, MODE_ACTIVE});
    end
    acc(0, 16'h6040, 1, 2, 0, 16'h007F);
    acc(32'h06010002, 16'h6044);
    acc(32'h06020000, 16'h1234, 0);
    acc(32'h06090011, 16'h6040, 0, 2, 1);
    acc(32'h06010003, 16'h6040, 1, 2, 1);
    acc(32'h05040001, 16'h6040, 7);
    acc(32'h05040001, 16'h6040, 2);
    acc(32'h06070010, 16'h6040, 1, 0);
    acc(32'h06070012, 16'h6040, 1, 3);
    acc(32'h06070013, 16'h6040, 1, 1);
    acc(32'h06090030, 16'h6060, 1, 1, 0, 5);
    acc(32'h06090032, 16'h604F, 1, 2, 0, 16'h8000);
    acc(32'h06090031, 16'h1600, 1, 1, 0, 9);
    acc(32'h06090036, 16'h6042, 1, 2, 0, 16'hFFF0);
    acc(32'h08000020, 16'h6040, 1, 2, 0, 0, 7'h40);
    acc(32'h08000021, 16'h6040, 1, 2, 0, 0, 7'h20);
    acc(32'h08000022, 16'h6040, 1, 2, 0, 0, 7'h10);
    acc(32'h06060000, 16'h6040, 1, 2, 0, 0, 7'h08);
    chk(DRIVE_COMMAND, 16'h007F);
    CLK_EN = 1'b0;
    i_foar_host_model.xfer({3'h1, 16'h6040, 8'h00, 3'h2, 32'h00000001, 2'b00}, rv, rs);
    CLK_EN = 1'b1;
    chk({rv, DRIVE_COMMAND}, {1'b0, 16'h007F});
    acc(32'h06090033, 16'h1600, 1, 4, 1, 32'h60400010, 7'h04);
    acc(32'h06040041, 16'h1600, 1, 4, 1, 32'h60430010);
    acc(32'h06040042, 16'h1600, 1, 4, 1, 32'h60400048);
    acc(0, 16'h1600, 1, 1, 0, 1);
    acc(0, 16'h1600, 0);
    chk({rs.len, rs.data}, {3'h1, 32'h00000001});
    acc(0, 16'h604F, 3);
    acc(0, 16'h0000, 2, 1, 0, 32'h000000A5);
    acc(0, 16'h0000, 2, 1, 0, 32'h0000003C, 7'h03);
    chk(ACCEL_RAMP_TIME, 16'h3CA5);
    acc(0, 16'h604F, 3);
    acc(32'h05030000, 16'h0000, 2, 1, 0, 0, 7'h02);
    acc(0, 16'h6050, 3);
    acc(0, 16'h0000, 2, 4, 0, 32'h01020304);
    acc(32'h05040005, 16'h0000, 2, 1, 0, 0, 7'h02);
    acc(0, 16'h6050, 3);
    for (int i = 0; i < 3 * TMO && RSP_VALID !== 1'b1; i++) begin
      @(posedge CLK_SYS);
      #1;
    end
    chk({RSP_VALID, RSP.abort, RSP.code}, {2'b11, 32'h05040000});
    repeat (TMO + 5) @(posedge CLK_SYS);
    #1 chk({LINK_TIMEOUT_WARNING, EVENT_ID}, {1'b1, 8'h51});
    HOST_FRAME = 1'b1;
    @(posedge CLK_SYS);
    #1 HOST_FRAME = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1 chk(LINK_TIMEOUT_WARNING, 0);
    {SYNC_MODE, CMD_FROM_CARD} = 2'b11;
    repeat (TMO + 5) @(posedge CLK_SYS);
    #1 chk({SYNC_LOSS_FAULT, SYNC_LOSS_WARNING, EVENT_ID}, {2'b10, 8'hA1});
    {CMD_FROM_CARD, SYNC_PACKET} = 2'b01;
    @(posedge CLK_SYS);
    #1 SYNC_PACKET = 1'b0;
    repeat (TMO + 5) @(posedge CLK_SYS);
    #1 chk({SYNC_LOSS_FAULT, SYNC_LOSS_WARNING, EVENT_ID}, {2'b01, 8'h6F});
    {SYNC_MODE, CARD_PRESENT} = 2'b00;
    repeat (3) @(posedge CLK_SYS);
    #1 chk({CARD_DETACHED_WARNING, EVENT_ID}, {1'b1, 8'h59});
    finish_test();
  end
endmodule : tb_top
bind foar_top foar_monitor i_foar_monitor (.*);
